// ==== hdl/sdr_consts.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of
 * the rate sequencer. Assumes inclusion by bare name from hdl/.
 */
`ifndef SDR_CONSTS_SVH
`define SDR_CONSTS_SVH

`define SDR_ADDR_CTRL 8'h00
`define SDR_ADDR_CHAN 8'h04
`define SDR_ADDR_STATUS 8'h08
`define SDR_ADDR_DATA 8'h0c

`define SDR_CTRL_RST 16'h8001
`define SDR_CHAN_RST 8'h01
`define SDR_READY_BIT 7

`define SDR_RESP_OKAY 2'b00
`define SDR_RESP_SLVERR 2'b10

`define SDR_CLK_KHZ 125000
`define SDR_MCLK_KHZ 4920
`define SDR_MCLK_DIV (`SDR_CLK_KHZ / `SDR_MCLK_KHZ)
`define SDR_PRE_W 8
`define SDR_WORD_LEN 1024

`define SDR_SETTLE_CHOP 3'h2
`define SDR_SETTLE_ORD4 3'h4
`define SDR_SETTLE_ORD3 3'h3
`define SDR_MULT_PLAIN 3'h1

`endif

// ==== hdl/sdr_pkg.sv ====
/*
 * Types shared by the rate sequencer and its period timer.
 * Assumes sdr_consts.svh is on the include path.
 */
`include "sdr_consts.svh"

package sdr_pkg;

    typedef enum logic [1:0] {
        SDR_IDLE = 2'b00,
        SDR_SETTLE = 2'b01,
        SDR_RUN = 2'b10
    } sdr_state_e;

    // Control word as software sees it
    typedef struct packed {
        logic run;
        logic append;
        logic dual_notch;
        logic zero_lat;
        logic chop;
        logic order3;
        logic [9:0] rate;
    } sdr_cfg_s;

    // Controls towards modulator and decimation filter
    typedef struct packed {
        logic [2:0] chan;
        logic mod_rst;
        logic chop_pol;
        logic order3;
        logic dual_notch;
    } sdr_fe_s;

    typedef struct packed {
        logic [22:0] cnt;
        logic [`SDR_PRE_W-1:0] pre;
    } sdr_tmr_s;

    typedef struct packed {
        sdr_state_e fsm;
        sdr_cfg_s cfg;
        logic [7:0] chan_en;
        logic [2:0] chan;
        logic [2:0] res_chan;
        logic [2:0] per_cnt;
        logic pol;
        logic mod_rst;
        logic ready_n;
        logic [23:0] prev;
        logic [31:0] data;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } sdr_state_s;

endpackage : sdr_pkg

// ==== hdl/sdr_rate_timer.sv ====
/*
 * Output-rate period timer: master clock enable from a divider, then a
 * count of 1024 x rate divider x multiplier master clock cycles.
 * Assumes restart and settings come from logic on aclk.
 */
`timescale 1ns/10ps
`include "sdr_consts.svh"

module sdr_rate_timer #(
    parameter int MCLK_DIV = `SDR_MCLK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    input wire logic [9:0] rate,
    input wire logic [2:0] mult,
    output logic period_end
);
    import sdr_pkg::*;

    sdr_tmr_s t_r;
    sdr_tmr_s t_nxt;
    logic mclk_en;
    logic [9:0] rate_eff;
    logic [12:0] prod;
    logic [22:0] lim;

    always_comb begin
        // A zero divider is illegal; run it as one
        rate_eff = (rate == 10'h0) ? 10'h1 : rate;
        prod = {3'h0, rate_eff} * {10'h0, mult};
        lim = {prod - 13'h1, 10'h3ff};
        mclk_en = (t_r.pre == `SDR_PRE_W'(MCLK_DIV - 1));
        // No period ends while the front end is held in reset
        period_end = mclk_en && !restart && (t_r.cnt >= lim);
        t_nxt = t_r;
        if (restart) begin
            t_nxt = '0;
        end else if (mclk_en) begin
            t_nxt.pre = '0;
            t_nxt.cnt = period_end ? 23'h0 : t_r.cnt + 23'h1;
        end else begin
            t_nxt.pre = t_r.pre + `SDR_PRE_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    property p_cnt_wrap;
        @(posedge aclk) disable iff (!aresetn)
        mclk_en && !restart && t_r.cnt >= lim |=> t_r.cnt == 23'h0;
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap)
        else $error("period counter did not wrap at its limit");

endmodule : sdr_rate_timer

// ==== hdl/sdr_rate_seq.sv ====
/*
 * Conversion timing and channel sequencer of a sigma-delta converter,
 * with an AXI4-Lite register slave. Assumes the filter result input
 * comes from logic on aclk and holds the latest filter output.
 */
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
// Overview of operation
// - Chop swaps input polarity per settled phase and averages phases.
// - Chop rate is clock over order x 1024 x divider.
// - Chop settling lasts two output periods for both filters.
// - Dual notch bit plus 50 Hz rate gives 50 and 60 Hz notches.
// - Zero latency makes every conversion wait a full settling time.
// - Zero latency rate does not depend on enabled channel count.
// - Eight channel enable bits choose the sequenced channels.
// - Continuous mode converts each enabled channel in turn unprompted.
// - Ready goes low whenever a valid result is available.
// - Selecting a channel resets modulator and filter; ready goes high only on the first select from idle.
// - After a channel change wait full settling before the result.
// - After a result move on while the old result stays readable.
// - A full pass takes settling time times enabled channel count.
// - Fourth order plain mode settles in four output periods.
// - Order select zero gives fourth order, one gives third order.
// - Plain rate is clock over 1024 x divider, settle four or three.
// - Appended status low nibble holds the converted channel.
`timescale 1ns/10ps
`include "sdr_consts.svh"

module sdr_rate_seq #(
    parameter int MCLK_DIV = `SDR_MCLK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [23:0] filter_result,
    output sdr_pkg::sdr_fe_s fe_ctrl,
    output logic conversion_ready_n
);
    import sdr_pkg::*;

    sdr_state_s st_r;
    sdr_state_s st_nxt;
    logic period_end;
    logic [2:0] mult;
    logic [2:0] settle_n;
    logic multi;
    logic cfg_wr;
    logic rd_clr;
    logic result_stb;
    logic advance;
    logic [23:0] res;
    logic [24:0] diff;
    logic [2:0] seq_next;

    // First enabled channel after 'from', ascending with wrap
    function automatic logic [2:0] next_chan(input logic [2:0] from,
                                             input logic [7:0] en);
        logic [2:0] idx;
        logic [2:0] pick;
        pick = from;
        for (int i = 8; i >= 1; i--) begin
            idx = 3'(from + 3'(i));
            if (en[idx]) begin
                pick = idx;
            end
        end
        return pick;
    endfunction : next_chan

    sdr_rate_timer #(
        .MCLK_DIV(MCLK_DIV)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(st_r.mod_rst),
        .rate(st_r.cfg.rate),
        .mult(mult),
        .period_end(period_end)
    );

    always_comb begin
        // Chop stretches the period by the filter order
        if (st_r.cfg.chop) begin
            mult = st_r.cfg.order3 ? `SDR_SETTLE_ORD3 : `SDR_SETTLE_ORD4;
            settle_n = `SDR_SETTLE_CHOP;
        end else begin
            mult = `SDR_MULT_PLAIN;
            settle_n = st_r.cfg.order3 ? `SDR_SETTLE_ORD3
                                       : `SDR_SETTLE_ORD4;
        end
        multi = (st_r.chan_en & (st_r.chan_en - 8'h1)) != 8'h0;
        // Average the two polarities so the offset cancels
        if (st_r.pol) begin
            diff = {st_r.prev[23], st_r.prev}
                 - {filter_result[23], filter_result};
        end else begin
            diff = {filter_result[23], filter_result}
                 - {st_r.prev[23], st_r.prev};
        end
        res = st_r.cfg.chop ? diff[24:1] : filter_result;
        seq_next = next_chan(st_r.chan, st_r.chan_en);
    end

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;

    always_comb begin
        st_nxt = st_r;
        st_nxt.mod_rst = 1'b0;
        cfg_wr = 1'b0;
        rd_clr = 1'b0;
        result_stb = 1'b0;
        advance = 1'b0;

        // Write channel: address and data in either order
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `SDR_RESP_OKAY;
            unique case (st_r.awaddr)
                `SDR_ADDR_CTRL: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.cfg[7:0] = st_r.wdata[7:0];
                    end
                    if (st_r.wstrb[1]) begin
                        st_nxt.cfg[15:8] = st_r.wdata[15:8];
                    end
                    cfg_wr = st_r.wstrb[1:0] != 2'b00;
                end
                `SDR_ADDR_CHAN: begin
                    if (st_r.wstrb[0]) begin
                        st_nxt.chan_en = st_r.wdata[7:0];
                    end
                    cfg_wr = st_r.wstrb[0];
                end
                `SDR_ADDR_STATUS, `SDR_ADDR_DATA: begin
                    st_nxt.bresp = `SDR_RESP_OKAY;
                end
                default: begin
                    st_nxt.bresp = `SDR_RESP_SLVERR;
                end
            endcase
        end

        // Read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `SDR_RESP_OKAY;
            unique case (s_axi_araddr)
                `SDR_ADDR_CTRL: st_nxt.rdata = {16'h0, st_r.cfg};
                `SDR_ADDR_CHAN: st_nxt.rdata = {24'h0, st_r.chan_en};
                `SDR_ADDR_STATUS: begin
                    st_nxt.rdata = {24'h0, st_r.ready_n, 4'h0,
                                    st_r.res_chan};
                end
                `SDR_ADDR_DATA: begin
                    st_nxt.rdata = st_r.data;
                    rd_clr = 1'b1;
                end
                default: begin
                    st_nxt.rdata = 32'h0;
                    st_nxt.rresp = `SDR_RESP_SLVERR;
                end
            endcase
        end
        // Reading the data word releases ready
        if (rd_clr) begin
            st_nxt.ready_n = 1'b1;
        end

        // Sequencer; a configuration change restarts from idle
        if (cfg_wr) begin
            st_nxt.fsm = SDR_IDLE;
            st_nxt.ready_n = 1'b1;
        end else begin
            unique case (st_r.fsm)
                SDR_IDLE: begin
                    if (st_r.cfg.run && st_r.chan_en != 8'h0) begin
                        st_nxt.mod_rst = 1'b1;
                        st_nxt.ready_n = 1'b1;
                        st_nxt.chan = next_chan(3'h7, st_r.chan_en);
                        st_nxt.per_cnt = 3'h0;
                        st_nxt.pol = 1'b0;
                        st_nxt.fsm = SDR_SETTLE;
                    end
                end
                SDR_SETTLE: begin
                    if (period_end) begin
                        st_nxt.prev = filter_result;
                        st_nxt.pol = st_r.cfg.chop ^ st_r.pol;
                        if (st_r.per_cnt == settle_n - 3'h1) begin
                            result_stb = 1'b1;
                        end else begin
                            st_nxt.per_cnt = st_r.per_cnt + 3'h1;
                        end
                    end
                end
                SDR_RUN: begin
                    if (period_end) begin
                        st_nxt.prev = filter_result;
                        st_nxt.pol = st_r.cfg.chop ^ st_r.pol;
                        result_stb = 1'b1;
                    end
                end
                default: begin
                    st_nxt.fsm = SDR_IDLE;
                end
            endcase
        end

        if (result_stb) begin
            st_nxt.data = {st_r.cfg.append ? {4'h0, 1'b0, st_r.chan}
                                           : 8'h0, res};
            st_nxt.res_chan = st_r.chan;
            st_nxt.ready_n = 1'b0;
            // Zero latency or several channels settle every conversion
            advance = st_r.cfg.zero_lat || multi;
            if (!st_r.cfg.run) begin
                st_nxt.fsm = SDR_IDLE;
            end else if (advance) begin
                st_nxt.mod_rst = 1'b1;
                st_nxt.chan = seq_next;
                st_nxt.per_cnt = 3'h0;
                st_nxt.pol = 1'b0;
                st_nxt.fsm = SDR_SETTLE;
            end else begin
                st_nxt.fsm = SDR_RUN;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.cfg <= `SDR_CTRL_RST;
            st_r.chan_en <= `SDR_CHAN_RST;
            st_r.ready_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        fe_ctrl.chan = st_r.chan;
        fe_ctrl.mod_rst = st_r.mod_rst;
        fe_ctrl.chop_pol = st_r.pol;
        fe_ctrl.order3 = st_r.cfg.order3;
        fe_ctrl.dual_notch = st_r.cfg.dual_notch;
    end
    assign conversion_ready_n = st_r.ready_n;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_cfg_valid;
        cfg_wr ##1 (st_r.cfg.run && st_r.chan_en != 8'h0);
    endsequence

    property p_restart;
        s_cfg_valid |=> st_r.mod_rst && st_r.ready_n &&
                        st_r.fsm == SDR_SETTLE;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not reset front end and ready");

    property p_ready_low;
        result_stb && !cfg_wr |=> !conversion_ready_n;
    endproperty
    a_ready_low: assert property (p_ready_low)
        else $error("ready not low after result");

    property p_settle_end;
        result_stb && st_r.fsm == SDR_SETTLE
            |-> st_r.per_cnt == settle_n - 3'h1;
    endproperty
    a_settle_end: assert property (p_settle_end)
        else $error("result before full settling");

    property p_settle_chop;
        st_r.fsm == SDR_SETTLE && st_r.cfg.chop |-> st_r.per_cnt < 3'h2;
    endproperty
    a_settle_chop: assert property (p_settle_chop)
        else $error("chop settling longer than two periods");

    property p_settle_ord4;
        st_r.fsm == SDR_SETTLE && !st_r.cfg.chop && !st_r.cfg.order3
            && !cfg_wr && period_end |=> st_r.per_cnt != 3'h0 ||
            $past(st_r.per_cnt) == 3'h3;
    endproperty
    a_settle_ord4: assert property (p_settle_ord4)
        else $error("fourth order settling not four periods");

    property p_chop_pol;
        period_end && st_r.cfg.chop && st_r.fsm == SDR_RUN && !cfg_wr
            |=> fe_ctrl.chop_pol != $past(fe_ctrl.chop_pol);
    endproperty
    a_chop_pol: assert property (p_chop_pol)
        else $error("chop polarity did not swap");

    property p_chan_en;
        st_r.fsm != SDR_IDLE |-> st_r.chan_en[st_r.chan];
    endproperty
    a_chan_en: assert property (p_chan_en)
        else $error("disabled channel selected");

    property p_zl_advance;
        result_stb && st_r.cfg.zero_lat && st_r.cfg.run && !cfg_wr
            |=> fe_ctrl.mod_rst ##1 !fe_ctrl.mod_rst;
    endproperty
    a_zl_advance: assert property (p_zl_advance)
        else $error("zero latency conversion did not restart");

    property p_status_chan;
        result_stb && st_r.cfg.append && !cfg_wr
            |=> st_r.data[27:24] == {1'b0, $past(st_r.chan)};
    endproperty
    a_status_chan: assert property (p_status_chan)
        else $error("status nibble does not match channel");

endmodule : sdr_rate_seq

// ==== sim/sdr_filter_model.sv ====
/*
 * Behavioural modulator and decimation filter: the result follows the
 * selected channel and the input polarity.
 * Assumes fe_ctrl comes registered from the sequencer on the same clock.
 */
`timescale 1ns/10ps

module sdr_filter_model (
    input wire sdr_pkg::sdr_fe_s fe_ctrl,
    output logic [23:0] filter_result
);
    import sdr_pkg::*;

    logic [23:0] level;

    assign level = 24'h000100 + {21'h0, fe_ctrl.chan};

    // Swapped inputs give the negated level; a filter reset gives noise
    always_comb begin
        if (fe_ctrl.mod_rst) begin
            filter_result = 24'h5a5a5a;
        end else if (fe_ctrl.chop_pol) begin
            filter_result = -level;
        end else begin
            filter_result = level;
        end
    end

endmodule : sdr_filter_model

// ==== sim/sigma_delta_rate_sequencer_test.sv ====
/*
 * Self-checking bench of the rate sequencer: settling per mode, channel
 * order, appended status, ready flag, register reset values.
 * Assumes MCLK_DIV of 1, so one output period is 1024 x divider cycles, times the order with chop.
 */
`timescale 1ns/10ps
`include "sdr_consts.svh"

module sigma_delta_rate_sequencer_test;
    import sdr_pkg::*;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [31:0] cyc;
        logic [31:0] nxt;
    } sdr_row_s;

    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, ready_n;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, r;
    logic [23:0] fres;
    logic [2:0] expch [5];
    sdr_fe_s fe;
    sdr_row_s rows [6];
    int bad_count, samples_checked, cyc, t0, t1, dt;

    sdr_rate_seq #(.MCLK_DIV(1)) u_dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready),
        .filter_result(fres),
        .fe_ctrl(fe),
        .conversion_ready_n(ready_n)
    );

    sdr_filter_model u_filter (
        .fe_ctrl(fe),
        .filter_result(fres)
    );

    always #4 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc <= cyc + 1;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp,
             input string msg);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask : chk

    task stop_test;
        $display("Compares %0d, errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task axw(input logic [7:0] a, input logic [31:0] d,
             output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axw

    task axr(input logic [7:0] a, output logic [31:0] d,
             output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axr

    // Channel select pulse, then the cycle count until a result is ready
    task wait_sel(output int t);
        int n;
        n = 0;
        while (fe.mod_rst !== 1'b1 && n < 50) begin
            @(posedge aclk);
            n++;
        end
        t = cyc;
    endtask : wait_sel

    task wait_res(input int t, output int d);
        int n;
        n = 0;
        while (ready_n !== 1'b0 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 20000) begin
            bad_count++;
            $display("ERROR %0t no result within limit", $time);
        end
        d = cyc - t;
    endtask : wait_res

    initial begin
        #(8 * 90000);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        cyc = 0;
        bad_count = 0;
        samples_checked = 0;
        // Divider stays within 1..1023 in every row
        rows[0] = '{16'h8001, 32'd4096, 32'd1024};
        rows[1] = '{16'h8401, 32'd3072, 32'd1024};
        rows[2] = '{16'h8801, 32'd8192, 32'd4096};
        rows[3] = '{16'h8c01, 32'd6144, 32'd3072};
        rows[4] = '{16'hb002, 32'd8192, 32'd8192};
        rows[5] = '{16'ha801, 32'd8192, 32'd4096};
        expch = '{3'h0, 3'h3, 3'h5, 3'h0, 3'h3};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Plain, third order, chop both orders, zero latency, chop notch
        for (int i = 0; i < 6; i++) begin
            axw(`SDR_ADDR_CHAN, 32'h1, r);
            axw(`SDR_ADDR_CTRL, {16'h0, rows[i].ctrl}, r);
            chk(32'(r), 32'(`SDR_RESP_OKAY), "ctrl write resp");
            wait_sel(t0);
            chk(32'(fe.mod_rst), 32'h1, "select pulse");
            chk(32'(fe.order3), 32'(rows[i].ctrl[10]), "order");
            chk(32'(fe.dual_notch), 32'(rows[i].ctrl[13]), "notch");
            wait_res(t0, dt);
            t1 = cyc;
            chk(32'(dt >= rows[i].cyc - 1 && dt <= rows[i].cyc + 3), 32'h1,
                "settle time");
            axr(`SDR_ADDR_DATA, rd, r);
            chk(rd, 32'h100, "averaged result");
            @(posedge aclk);
            chk(32'(ready_n), 32'h1, "ready after read");
            // Following result: one period, or full settling in zero latency
            wait_res(t1, dt);
            chk(32'(dt >= rows[i].nxt - 1 && dt <= rows[i].nxt + 3), 32'h1,
                "next result");
            axr(`SDR_ADDR_DATA, rd, r);
            chk(rd, 32'h100, "second result");
        end
        // Channels 0, 3, 5 in turn, status appended
        axw(`SDR_ADDR_CHAN, 32'h29, r);
        axw(`SDR_ADDR_CTRL, 32'hc401, r);
        wait_sel(t0);
        t1 = t0;
        chk(32'(fe.chan), 32'h0, "first channel");
        for (int k = 1; k < 5; k++) begin
            wait_res(t0, dt);
            chk(32'(dt >= 3071 && dt <= 3075), 32'h1, "chan settle");
            chk({28'h0, fe.mod_rst, fe.chan}, {28'h0, 1'b1, expch[k]},
                "next channel");
            if (k == 3) begin
                chk(32'(cyc - t1 >= 9213 && cyc - t1 <= 9225), 32'h1,
                    "full pass");
            end
            t0 = cyc;
            axr(`SDR_ADDR_DATA, rd, r);
            chk(rd, {5'h0, expch[k-1], 24'h000100 + 24'(expch[k-1])},
                "tagged result");
            @(posedge aclk);
            chk(32'(ready_n), 32'h1, "ready raised");
        end
        // Second reset in mid run, then register defaults and odd addresses
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(32'(fe), 32'h0, "fe in reset");
        chk(32'(ready_n), 32'h1, "ready in reset");
        aresetn <= 1'b1;
        axr(`SDR_ADDR_CTRL, rd, r);
        chk(rd, 32'(`SDR_CTRL_RST), "ctrl reset");
        axr(`SDR_ADDR_CHAN, rd, r);
        chk(rd, 32'(`SDR_CHAN_RST), "chan reset");
        axr(`SDR_ADDR_STATUS, rd, r);
        chk(32'(rd[`SDR_READY_BIT]), 32'h1, "status ready bit");
        axr(8'h10, rd, r);
        chk(rd, 32'h0, "unmapped read data");
        chk(32'(r), 32'(`SDR_RESP_SLVERR), "unmapped read");
        axw(8'h14, 32'h5, r);
        chk(32'(r), 32'(`SDR_RESP_SLVERR), "unmapped write");
        axw(`SDR_ADDR_STATUS, 32'hff, r);
        chk(32'(r), 32'(`SDR_RESP_OKAY), "read-only write");
        // Run cleared: no channel select follows
        axw(`SDR_ADDR_CTRL, 32'h0001, r);
        wait_sel(t0);
        chk(32'(fe.mod_rst), 32'h0, "stopped");
        stop_test();
    end

endmodule : sigma_delta_rate_sequencer_test
